//--- verilog/mmd_top.sv
// Chip mode, power mode and global address decode with AXI4-Lite control
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

// Function
// - Writes to reserved space are dropped; reads there return zero.
// - Access to an unimplemented flash page raises illegal address reset.
// - RAM starts at 0x800 and ends at 0x7FF plus its byte count.
// - Flash ends at 0x3FFFF, starting at 0x40000 minus its byte count.
// - Information row mapped only while visibility bit is one, else reserved.
// - Read-only 16-bit part identifier, high byte at 0x1A, low at 0x1B.
// - Identifier nibbles: major family, minor family, major rev, minor rev.
// - Mode strap level is captured into the mode bit at reset release.
// - Strap high selects normal single-chip, low selects special single-chip.
// - Software may change mode only in the limited permitted direction.
// - Normal mode starts the CPU from on-chip memory at the reset vector.
// - Special mode enables background debug and runs the monitor program.
// - Stop instruction enters stop; reset, die interrupt or unmasked irq exit.
// - Wait gates CPU clock only; reset, die interrupt or unmasked irq exit.
// - Enabled oscillator monitor issues system reset on clock timeout.
// - Core and bus clock come from the locked loop or the oscillator.
// - Flash uses the bus clock as its clock and program timing base.
// - Watchdog and periodic timer each have a freeze-in-debug option.
module mmd_top
	import mmd_pkg::*;
(
	input  wire logic        i_mclk,            // Bus clock
	input  wire logic        i_rst_n,           // Synchronous reset, active low
	input  wire logic        i_mode_select_strap, // Mode strap level
	input  wire logic        i_cpu_valid,       // CPU/debug bus access strobe
	input  wire logic        i_cpu_write,       // Access is a write
	input  wire logic [17:0] i_cpu_addr,        // Global address
	input  wire logic        i_cpu_stop,        // Stop instruction executed
	input  wire logic        i_wait_instruction, // Wait instruction executed
	input  wire logic        i_companion_die_interrupt, // Die link interrupt
	input  wire logic        i_irq_pending,     // Any unmasked CPU interrupt
	input  wire logic        i_osc_tick,        // Oscillator activity toggle seen
	input  wire logic        i_bdm_active,      // Background debug active
	input  wire logic [7:0]  i_periph_rdata,    // Read data from register blocks
	output logic [4:0]       o_sel,             // Region select: ram,flash,regs,info,resv
	output logic             o_cpu_write_en,    // Write permitted to selected region
	output logic             o_cpu_rdata_zero,  // Force zero read data
	output logic [7:0]       o_ident_rdata,     // Identifier byte for reads
	output logic             o_ident_hit,       // Access hits identifier bytes
	output logic             o_sys_reset,       // System reset request
	output logic             o_special_mode,    // Special single-chip mode
	output logic             o_bdm_enable,      // Background debug enabled
	output logic             o_monitor_boot,    // Boot from monitor program
	output logic             o_cpu_clk_en,      // CPU clock gate
	output logic             o_periph_clk_en,   // Peripheral clock gate
	output logic             o_clk_from_osc,    // Bus clock source select
	output logic             o_flash_clk_en,    // Flash clock and timing base
	output logic             o_freeze_wdog,     // Watchdog frozen
	output logic             o_freeze_pit,      // Periodic timer frozen
	output logic             o_irq,             // Interrupt, active high level
	input  wire logic [31:0] s_axi_awaddr,      // AXI write address
	input  wire logic        s_axi_awvalid,     // AXI write address valid
	output logic             s_axi_awready,     // AXI write address ready
	input  wire logic [31:0] s_axi_wdata,       // AXI write data
	input  wire logic [3:0]  s_axi_wstrb,       // AXI write strobes
	input  wire logic        s_axi_wvalid,      // AXI write data valid
	output logic             s_axi_wready,      // AXI write data ready
	output logic [1:0]       s_axi_bresp,       // AXI write response
	output logic             s_axi_bvalid,      // AXI write response valid
	input  wire logic        s_axi_bready,      // AXI write response ready
	input  wire logic [31:0] s_axi_araddr,      // AXI read address
	input  wire logic        s_axi_arvalid,     // AXI read address valid
	output logic             s_axi_arready,     // AXI read address ready
	output logic [31:0]      s_axi_rdata,       // AXI read data
	output logic [1:0]       s_axi_rresp,       // AXI read response
	output logic             s_axi_rvalid,      // AXI read data valid
	input  wire logic        s_axi_rready       // AXI read data ready
);

	mmd_state_t           st;
	mmd_state_t           next_st;
	mmd_sel_t             sel;
	logic [15:0]          part_ident;
	logic                 wr_go;
	logic                 rd_go;
	logic [7:0]           rd_ofs;
	logic [MMD_EVT_W-1:0] evt;
	logic [MMD_EVT_W-1:0] w1c;
	logic                 wake;
	logic                 clkmon_timeout;

	assign part_ident = {MMD_ID_MAJOR_FAM, MMD_ID_MINOR_FAM,
		MMD_ID_MAJOR_REV, MMD_ID_MINOR_REV};

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb begin
		sel.regs  = (i_cpu_addr <= MMD_REG_TOP);
		sel.info  = (i_cpu_addr >= MMD_INFO_BASE) && (i_cpu_addr <= MMD_INFO_TOP)
			&& st.info_row_visible;
		sel.ram   = (i_cpu_addr >= MMD_RAM_BASE) && (i_cpu_addr <= MMD_RAM_TOP);
		sel.flash = (i_cpu_addr >= MMD_FLASH_LOW) && (i_cpu_addr <= MMD_FLASH_TOP);
		sel.resv  = !(sel.regs || sel.info || sel.ram || sel.flash);
	end

	assign o_sel            = i_cpu_valid ? sel : 5'h00;
	assign o_cpu_write_en   = i_cpu_valid && i_cpu_write && !sel.resv
		&& !o_ident_hit;
	assign o_cpu_rdata_zero = st.cpu_rdata_zero;
	assign o_ident_hit      = i_cpu_valid && sel.regs
		&& ((i_cpu_addr[7:0] == MMD_PART_HIGH_ADDR)
		|| (i_cpu_addr[7:0] == MMD_PART_LOW_ADDR)) && (i_cpu_addr[17:8] == 10'h000);
	assign o_ident_rdata    = (i_cpu_addr[7:0] == MMD_PART_HIGH_ADDR)
		? part_ident[15:8] : part_ident[7:0];

	// ----------------------------------------------------------------
	// Mode and power outputs
	// ----------------------------------------------------------------
	assign o_special_mode  = !st.mode_select;
	assign o_bdm_enable    = !st.mode_select;
	assign o_monitor_boot  = !st.mode_select;
	assign o_cpu_clk_en    = (st.pwr == MMD_RUN);
	assign o_periph_clk_en = (st.pwr != MMD_STOP);
	assign o_clk_from_osc  = st.clk_from_osc;
	assign o_flash_clk_en  = o_periph_clk_en;
	assign o_freeze_wdog   = st.freeze_wdog && i_bdm_active;
	assign o_freeze_pit    = st.freeze_pit && i_bdm_active;
	assign o_sys_reset     = st.sys_reset;
	assign o_irq           = |(st.irq_stat & st.irq_mask);
	assign wake            = i_companion_die_interrupt || i_irq_pending;

	// ----------------------------------------------------------------
	// Bus slave signalling
	// ----------------------------------------------------------------
	assign s_axi_awready = !st.aw_full && !st.bvalid;
	assign s_axi_wready  = !st.w_full && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	assign wr_go  = st.aw_full && st.w_full && !st.bvalid;
	assign rd_go  = s_axi_arvalid && s_axi_arready;
	assign rd_ofs = {s_axi_araddr[7:2], 2'b00};
	assign clkmon_timeout = st.clkmon_en && (st.clkmon_cnt == MMD_CLKMON_LIMIT);

	always_comb begin
		evt = '0;
		evt[MMD_EVT_ILLEGAL] = i_cpu_valid && (i_cpu_addr >= MMD_FLASH_PAGE_LOW)
			&& (i_cpu_addr < MMD_FLASH_LOW);
		evt[MMD_EVT_RESV]    = i_cpu_valid && sel.resv;
		evt[MMD_EVT_WAKE]    = (st.pwr != MMD_RUN) && wake;
		evt[MMD_EVT_CLKMON]  = clkmon_timeout;
	end

	always_comb begin
		next_st = st;
		w1c     = '0;
		next_st.cpu_rdata_zero = i_cpu_valid && !i_cpu_write && sel.resv;
		next_st.sys_reset = evt[MMD_EVT_ILLEGAL] || clkmon_timeout;
		// Oscillator monitor count restarts on each oscillator tick
		if (!st.clkmon_en || i_osc_tick) begin
			next_st.clkmon_cnt = 8'h00;
		end else if (!clkmon_timeout) begin
			next_st.clkmon_cnt = 8'(st.clkmon_cnt + 8'h01);
		end
		// Strap caught at first edge after reset release
		if (!st.strap_taken) begin
			next_st.mode_select = i_mode_select_strap;
			next_st.strap_taken = 1'b1;
		end
		unique case (st.pwr)
			MMD_RUN: begin
				if (i_cpu_stop) begin
					next_st.pwr = MMD_STOP;
				end else if (i_wait_instruction) begin
					next_st.pwr = MMD_WAIT;
				end
			end
			MMD_STOP: begin
				if (wake) begin
					next_st.pwr = MMD_RUN;
				end
			end
			MMD_WAIT: begin
				if (wake) begin
					next_st.pwr = MMD_RUN;
				end
			end
			default: begin
				next_st.pwr = MMD_RUN;
			end
		endcase
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_full = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			next_st.aw_full = 1'b0;
			next_st.w_full  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = MMD_RESP_OKAY;
			if (st.w_strb[0]) begin
				unique case (st.aw_addr)
					MMD_OFS_MAP_CTRL: next_st.info_row_visible = st.w_data[0];
					// Only normal to special is allowed at run time
					MMD_OFS_MODE: begin
						if (!st.w_data[0]) begin
							next_st.mode_select = 1'b0;
						end
					end
					MMD_OFS_POWER: next_st.clk_from_osc = st.w_data[0];
					MMD_OFS_FREEZE: begin
						next_st.freeze_wdog = st.w_data[0];
						next_st.freeze_pit  = st.w_data[1];
					end
					MMD_OFS_IRQ_STAT: w1c = st.w_data[MMD_EVT_W-1:0];
					MMD_OFS_IRQ_MASK: next_st.irq_mask = st.w_data[MMD_EVT_W-1:0];
					MMD_OFS_CLOCK: next_st.clkmon_en = st.w_data[0];
					MMD_OFS_PART_HIGH, MMD_OFS_PART_LOW: next_st.bresp = MMD_RESP_OKAY;
					default: next_st.bresp = MMD_RESP_SLVERR;
				endcase
			end
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Set wins over write-one-to-clear
		next_st.irq_stat = (st.irq_stat & ~w1c) | evt;
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = MMD_RESP_OKAY;
			next_st.rdata  = 32'h00000000;
			unique case (rd_ofs)
				MMD_OFS_PART_HIGH: next_st.rdata = {24'h000000, part_ident[15:8]};
				MMD_OFS_PART_LOW:  next_st.rdata = {24'h000000, part_ident[7:0]};
				MMD_OFS_MAP_CTRL:  next_st.rdata = {31'h00000000, st.info_row_visible};
				MMD_OFS_MODE:      next_st.rdata = {29'h00000000, st.pwr, st.mode_select};
				MMD_OFS_POWER:     next_st.rdata = {31'h00000000, st.clk_from_osc};
				MMD_OFS_FREEZE:    next_st.rdata = {30'h00000000, st.freeze_pit,
					st.freeze_wdog};
				MMD_OFS_IRQ_STAT:  next_st.rdata = {28'h0000000, st.irq_stat};
				MMD_OFS_IRQ_MASK:  next_st.rdata = {28'h0000000, st.irq_mask};
				MMD_OFS_CLOCK:     next_st.rdata = {31'h00000000, st.clkmon_en};
				default:           next_st.rresp = MMD_RESP_SLVERR;
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st      <= '0;
			st.pwr  <= MMD_RUN;
		end else begin
			st <= next_st;
		end
	end

	logic unused_periph;
	assign unused_periph = ^i_periph_rdata;

endmodule : mmd_top

//--- verilog/mmd_pkg.sv
// Package: constants and types for the chip mode and address decode block
package mmd_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [17:0] MMD_REG_BASE   = 18'h00000;
	localparam logic [17:0] MMD_REG_TOP    = 18'h003ff;
	localparam logic [17:0] MMD_INFO_BASE  = 18'h00400;
	localparam logic [17:0] MMD_INFO_TOP   = 18'h0047f;
	localparam logic [17:0] MMD_RAM_BASE   = 18'h00800;
	localparam logic [17:0] MMD_RAM_ANCHOR = 18'h007ff;
	localparam logic [17:0] MMD_RAM_BYTES  = 18'h00800;
	localparam logic [17:0] MMD_RAM_TOP    = 18'(MMD_RAM_ANCHOR + MMD_RAM_BYTES);
	localparam logic [18:0] MMD_FLASH_END  = 19'h40000;
	localparam logic [17:0] MMD_FLASH_TOP  = 18'h3ffff;
	localparam logic [18:0] MMD_FLASH_BYTES = 19'h08000;
	localparam logic [17:0] MMD_FLASH_LOW  = 18'(MMD_FLASH_END - MMD_FLASH_BYTES);
	localparam logic [17:0] MMD_FLASH_PAGE_LOW = 18'h30000;
	localparam logic [7:0]  MMD_PART_HIGH_ADDR = 8'h1a;
	localparam logic [7:0]  MMD_PART_LOW_ADDR  = 8'h1b;

	// Identifier fields (values arbitrary)
	localparam logic [3:0]  MMD_ID_MAJOR_FAM = 4'h1;
	localparam logic [3:0]  MMD_ID_MINOR_FAM = 4'h2;
	localparam logic [3:0]  MMD_ID_MAJOR_REV = 4'h0;
	localparam logic [3:0]  MMD_ID_MINOR_REV = 4'h0;

	// ----------------------------------------------------------------
	// Register offsets on the control bus
	// ----------------------------------------------------------------
	// Identifier bytes: word index times four
	localparam logic [7:0]  MMD_OFS_PART_HIGH = 8'(MMD_PART_HIGH_ADDR << 2);
	localparam logic [7:0]  MMD_OFS_PART_LOW  = 8'(MMD_PART_LOW_ADDR << 2);
	localparam logic [7:0]  MMD_OFS_MAP_CTRL  = 8'h40;
	localparam logic [7:0]  MMD_OFS_MODE      = 8'h44;
	localparam logic [7:0]  MMD_OFS_POWER     = 8'h48;
	localparam logic [7:0]  MMD_OFS_FREEZE    = 8'h4c;
	localparam logic [7:0]  MMD_OFS_IRQ_STAT  = 8'h50;
	localparam logic [7:0]  MMD_OFS_IRQ_MASK  = 8'h54;
	localparam logic [7:0]  MMD_OFS_CLOCK     = 8'h58;

	localparam int          MMD_EVT_W       = 4;
	localparam int          MMD_EVT_ILLEGAL = 0;
	localparam int          MMD_EVT_RESV    = 1;
	localparam int          MMD_EVT_WAKE    = 2;
	localparam int          MMD_EVT_CLKMON  = 3;

	localparam logic [1:0]  MMD_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  MMD_RESP_SLVERR = 2'h2;

	// Oscillator monitor timeout in bus cycles
	localparam logic [7:0]  MMD_CLKMON_LIMIT = 8'hff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MMD_RUN, MMD_STOP, MMD_WAIT} mmd_pwr_t;

	typedef struct packed {
		logic        ram;
		logic        flash;
		logic        regs;
		logic        info;
		logic        resv;
	} mmd_sel_t;

	typedef struct packed {
		logic                 aw_full;
		logic [7:0]           aw_addr;
		logic                 w_full;
		logic [31:0]          w_data;
		logic [3:0]           w_strb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 info_row_visible;
		logic                 mode_select;
		logic                 strap_taken;
		mmd_pwr_t             pwr;
		logic                 clk_from_osc;
		logic                 clkmon_en;
		logic [7:0]           clkmon_cnt;
		logic                 freeze_wdog;
		logic                 freeze_pit;
		logic [MMD_EVT_W-1:0] irq_stat;
		logic [MMD_EVT_W-1:0] irq_mask;
		logic                 sys_reset;
		logic                 cpu_rdata_zero;
	} mmd_state_t;

endpackage : mmd_pkg

//--- testbench/mmd_chk.sv
// Checker: port-level assertions for the mode and decode block
`timescale 1ns/1ps
module mmd_chk
	import mmd_pkg::*;
(
	input wire logic        i_mclk,                    // Clock
	input wire logic        i_rst_n,                   // Reset
	input wire logic        i_mode_select_strap,       // Strap
	input wire logic        i_cpu_valid,               // Strobe
	input wire logic        i_cpu_write,               // Write
	input wire logic [17:0] i_cpu_addr,                // Address
	input wire logic        i_cpu_stop,                // Stop
	input wire logic        i_wait_instruction,        // Wait
	input wire logic        i_companion_die_interrupt, // Die irq
	input wire logic        i_irq_pending,             // Cpu irq
	input wire logic        i_bdm_active,              // Debug
	input wire logic [4:0]  o_sel,                     // Select
	input wire logic        o_cpu_write_en,            // Write ok
	input wire logic        o_cpu_rdata_zero,          // Zero read
	input wire logic [7:0]  o_ident_rdata,             // Ident
	input wire logic        o_ident_hit,               // Ident hit
	input wire logic        o_sys_reset,               // Reset req
	input wire logic        o_special_mode,            // Special
	input wire logic        o_bdm_enable,              // Debug on
	input wire logic        o_cpu_clk_en,              // Cpu clock
	input wire logic        o_periph_clk_en,           // Periph clock
	input wire logic        o_flash_clk_en,            // Flash clock
	input wire logic        o_freeze_wdog              // Freeze
);
	logic wake;
	assign wake = i_companion_die_interrupt | i_irq_pending;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_stop_req;
		o_cpu_clk_en && i_cpu_stop && !wake;
	endsequence
	sequence s_wait_req;
		o_cpu_clk_en && i_wait_instruction && !i_cpu_stop && !wake;
	endsequence
	resv_write_a: assert property (i_cpu_valid && o_sel[0] |-> !o_cpu_write_en)
		else $error("write enabled on reserved space");
	resv_zero_a: assert property (i_cpu_valid && !i_cpu_write && o_sel == 5'h01
		|=> o_cpu_rdata_zero) else $error("reserved read not zeroed");
	illegal_rst_a: assert property (i_cpu_valid && i_cpu_addr inside {[18'h30000:18'h37fff]}
		|=> o_sys_reset) else $error("no reset on missing flash page");
	ram_map_a: assert property (i_cpu_valid && i_cpu_addr inside {[18'h00800:18'h00fff]}
		|-> o_sel == 5'h10) else $error("ram decode wrong");
	flash_map_a: assert property (i_cpu_valid && i_cpu_addr >= 18'h38000
		|-> o_sel == 5'h08) else $error("flash decode wrong");
	regs_map_a: assert property (i_cpu_valid && i_cpu_addr <= 18'h003ff
		|-> o_sel == 5'h04) else $error("register decode wrong");
	ident_byte_a: assert property (i_cpu_valid && i_cpu_addr == 18'h0001a |-> o_ident_hit
		&& o_ident_rdata == {MMD_ID_MAJOR_FAM, MMD_ID_MINOR_FAM}) else $error("ident high wrong");
	strap_capture_a: assert property ($rose(i_rst_n) |=> o_special_mode == !$past(i_mode_select_strap)
		&& o_bdm_enable == o_special_mode) else $error("strap not captured");
	stop_enter_a: assert property (s_stop_req |=> !o_cpu_clk_en && !o_periph_clk_en
		&& !o_flash_clk_en) else $error("stop not entered");
	wait_enter_a: assert property (s_wait_req |=> !o_cpu_clk_en && o_periph_clk_en)
		else $error("wait not entered");
	wake_exit_a: assert property (!o_cpu_clk_en && wake |=> o_cpu_clk_en)
		else $error("no wake from low power");
	freeze_dbg_a: assert property (o_freeze_wdog |-> i_bdm_active)
		else $error("freeze without debug");
endmodule : mmd_chk

//--- testbench/mmd_cpu_model.sv
// CPU and debug host model driving the chip-side access port
`timescale 1ns/1ps
module mmd_cpu_model (
	input  wire logic        i_mclk,           // Bus clock
	output logic             o_valid = 1'h0,   // Access strobe
	output logic             o_write = 1'h0,   // Write access
	output logic [17:0]      o_addr  = 18'h0,  // Global address
	output logic             o_stop  = 1'h0,   // Stop instruction
	output logic             o_wait  = 1'h0    // Wait instruction
);
	task automatic go(input logic w, input logic [17:0] a);
		@(posedge i_mclk);
		o_valid <= 1'h1;
		o_write <= w;
		o_addr  <= a;
	endtask : go
	// Released address inverted so stale value never decodes
	task automatic idle();
		@(posedge i_mclk);
		o_valid <= 1'h0;
		o_addr  <= ~o_addr;
	endtask : idle
	task automatic pulse(input logic st);
		@(posedge i_mclk);
		o_stop <= st;
		o_wait <= !st;
		@(posedge i_mclk);
		o_stop <= 1'h0;
		o_wait <= 1'h0;
	endtask : pulse
endmodule : mmd_cpu_model

//--- testbench/mmd_top_tb.sv
// Testbench: mode, power and address decode block
`timescale 1ns/1ps
module mmd_top_tb;
	import mmd_pkg::*;
	logic i_mclk = 1'h0, i_rst_n = 1'h0, i_mode_select_strap = 1'h1, i_osc_tick = 1'h1;
	logic i_companion_die_interrupt = 1'h0, i_irq_pending = 1'h0, i_bdm_active = 1'h0;
	logic i_cpu_valid, i_cpu_write, i_cpu_stop, i_wait_instruction;
	logic [17:0] i_cpu_addr;
	logic [7:0]  i_periph_rdata = 8'h00;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [4:0]  o_sel;
	logic [7:0]  o_ident_rdata;
	logic o_cpu_write_en, o_cpu_rdata_zero, o_ident_hit, o_sys_reset, o_special_mode;
	logic o_bdm_enable, o_monitor_boot, o_cpu_clk_en, o_periph_clk_en, o_clk_from_osc;
	logic o_flash_clk_en, o_freeze_wdog, o_freeze_pit, o_irq;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	int num_errors = 0, comparisons = 0, n;
	logic [17:0] at [12] = '{18'h0001a, 18'h0001b, 18'h003ff, 18'h00400, 18'h007ff, 18'h00800,
		18'h00fff, 18'h01000, 18'h38000, 18'h3ffff, 18'h30000, 18'h37fff};
	logic [4:0]  es [12] = '{5'h04, 5'h04, 5'h04, 5'h01, 5'h01, 5'h10, 5'h10, 5'h01, 5'h08,
		5'h08, 5'h00, 5'h00};
	mmd_top mmd_top_i (.*);
	mmd_cpu_model mmd_cpu_model_i (.i_mclk(i_mclk), .o_valid(i_cpu_valid), .o_write(i_cpu_write),
		.o_addr(i_cpu_addr), .o_stop(i_cpu_stop), .o_wait(i_wait_instruction));
	always #10 i_mclk = ~i_mclk;
	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		num_errors++;
		$display("mismatch at %0t: wait timed out", $time);
		final_report();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata  <= d;
		s_axi_wstrb  <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 50; n++) begin
			@(posedge i_mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) hang();
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
		#1;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge i_mclk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 50; n++) begin
			@(posedge i_mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) hang();
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
	endtask : rdr
	// One CPU access; illegal pages only check the reset request and the ident hit
	task automatic cpu(input logic w, input logic [17:0] a, input logic [4:0] e);
		logic ill, idh;
		ill = a inside {[18'h30000:18'h37fff]};
		idh = a == 18'h0001a || a == 18'h0001b;
		mmd_cpu_model_i.go(w, a);
		#1;
		if (!ill) chk(o_sel, e);
		if (!ill) chk(o_cpu_write_en, w && !e[0] && !idh);
		chk(o_ident_hit, idh);
		if (idh) chk(o_ident_rdata, a[0] ? {MMD_ID_MAJOR_REV, MMD_ID_MINOR_REV}
			: {MMD_ID_MAJOR_FAM, MMD_ID_MINOR_FAM});
		mmd_cpu_model_i.idle();
		#1;
		chk(o_sys_reset, ill);
		if (!ill) chk(o_cpu_rdata_zero, !w && e[0]);
	endtask : cpu
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		@(posedge i_mclk);
		#1;
		chk({o_special_mode, o_monitor_boot, o_cpu_clk_en}, 3'h1);
		rdr(MMD_OFS_MODE);
		chk(rd[2:0], 3'h1);
		for (int i = 0; i < 12; i++) cpu(i[0], at[i], es[i]);
		wr(MMD_OFS_MAP_CTRL, 32'h1);
		chk(rs, MMD_RESP_OKAY);
		cpu(1'h0, 18'h0047f, 5'h02);
		cpu(1'h0, 18'h00480, 5'h01);
		chk(o_irq, 1'h0);
		wr(MMD_OFS_IRQ_MASK, 32'h2);
		chk(o_irq, 1'h1);
		rdr(MMD_OFS_IRQ_STAT);
		chk(rd[1:0], 2'h3);
		wr(MMD_OFS_IRQ_STAT, 32'h2);
		chk(o_irq, 1'h0);
		rdr(8'h60);
		chk(rd, 32'h0);
		chk(rs, MMD_RESP_SLVERR);
		wr(8'h60, 32'h1);
		chk(rs, MMD_RESP_SLVERR);
		rdr(MMD_OFS_PART_HIGH);
		chk(rd, {24'h0, MMD_ID_MAJOR_FAM, MMD_ID_MINOR_FAM});
		rdr(MMD_OFS_PART_LOW);
		chk(rd, {24'h0, MMD_ID_MAJOR_REV, MMD_ID_MINOR_REV});
		wr(MMD_OFS_MODE, 32'h0);
		chk({o_special_mode, o_bdm_enable}, 2'h3);
		wr(MMD_OFS_MODE, 32'h1);
		chk(o_special_mode, 1'h1);
		for (int k = 0; k < 2; k++) begin
			mmd_cpu_model_i.pulse(k[0]);
			#1;
			chk({o_cpu_clk_en, o_periph_clk_en, o_flash_clk_en}, k[0] ? 3'h0 : 3'h3);
			@(posedge i_mclk);
			{i_companion_die_interrupt, i_irq_pending} <= k[0] ? 2'h2 : 2'h1;
			@(posedge i_mclk);
			{i_companion_die_interrupt, i_irq_pending} <= 2'h0;
			#1;
			chk(o_cpu_clk_en, 1'h1);
		end
		wr(MMD_OFS_POWER, 32'h1);
		chk(o_clk_from_osc, 1'h1);
		wr(MMD_OFS_FREEZE, 32'h3);
		chk({o_freeze_wdog, o_freeze_pit}, 2'h0);
		@(posedge i_mclk);
		i_bdm_active <= 1'h1;
		@(posedge i_mclk);
		#1;
		chk({o_freeze_wdog, o_freeze_pit}, 2'h3);
		wr(MMD_OFS_CLOCK, 32'h1);
		@(posedge i_mclk);
		i_osc_tick <= 1'h0;
		for (n = 0; n < 400 && o_sys_reset !== 1'h1; n++) @(posedge i_mclk);
		chk(n >= 250 && n < 300, 1'h1);
		rdr(MMD_OFS_IRQ_STAT);
		chk(rd[3:0], 4'hd);
		i_osc_tick <= 1'h1;
		@(posedge i_mclk);
		{i_rst_n, i_mode_select_strap} <= 2'h0;
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		@(posedge i_mclk);
		#1;
		chk({o_special_mode, o_bdm_enable, o_monitor_boot, o_clk_from_osc}, 4'he);
		final_report();
	end
endmodule : mmd_top_tb
bind mmd_top mmd_chk mmd_chk_i (.*);
